// ### design/gpb_pkg.sv
`default_nettype none
package gpb_pkg;
    localparam int ADDR_W = 5;
    localparam int CLK_NS = 50;
    // Data settle before DAV, and IFC pulse width
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int IFC_NS = 100000;
    localparam int IFC_CYC = (IFC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] SETTLE_CNT = 2'(SETTLE_CYC);
    localparam logic [10:0] IFC_CNT = 11'(IFC_CYC);
    // Command byte groups, bits 6:5
    localparam logic [1:0] GRP_CMD = 2'h0;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3F;
    localparam logic [6:0] CMD_UNT = 7'h5F;
    localparam int STB_RQS_BIT = 6;
    typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_DAV} gpb_src_t;
    typedef enum logic [1:0] {ACC_IDLE, ACC_READY, ACC_HOLD} gpb_acc_t;
    typedef enum logic [1:0] {KIND_RAW, KIND_LISTEN, KIND_TALK} gpb_kind_t;
endpackage
`default_nettype wire

// ### design/gpb_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gpb_bus_if;
    // True-sense levels; an enable pulls the line to its true state
    logic [7:0] dev_dio_out, ctl_dio_out;
    logic dev_dio_oe, ctl_dio_oe;
    logic dev_dav_oe, dev_nrfd_oe, dev_ndac_oe, dev_eoi_oe, dev_srq_oe;
    logic ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe, ctl_eoi_oe;
    logic ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe;
    logic [7:0] dio;
    logic dav, nrfd, ndac, eoi, srq, atn, ifc, ren;
    // ****************************************
    // Wired-OR resolution
    // ****************************************
    assign dio = (dev_dio_oe ? dev_dio_out : 8'h00) | (ctl_dio_oe ? ctl_dio_out : 8'h00);
    assign dav = dev_dav_oe | ctl_dav_oe;
    assign nrfd = dev_nrfd_oe | ctl_nrfd_oe;
    assign ndac = dev_ndac_oe | ctl_ndac_oe;
    assign eoi = dev_eoi_oe | ctl_eoi_oe;
    assign srq = dev_srq_oe;
    assign atn = ctl_atn_oe;
    assign ifc = ctl_ifc_oe;
    assign ren = ctl_ren_oe;
    modport dev (
        input dio, dav, nrfd, ndac, eoi, srq, atn, ifc, ren,
        output dev_dio_out, dev_dio_oe, dev_dav_oe, dev_nrfd_oe, dev_ndac_oe,
        output dev_eoi_oe, dev_srq_oe
    );
    modport ctl (
        input dio, dav, nrfd, ndac, eoi, srq, atn, ifc, ren,
        output ctl_dio_out, ctl_dio_oe, ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe,
        output ctl_eoi_oe, ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe
    );
endinterface
`default_nettype wire

// ### design/gpb_acceptor.sv
`timescale 1ns/1ns
`default_nettype none
module gpb_acceptor (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic enable_in,
    input wire logic dav_in,
    input wire logic atn_in,
    input wire logic eoi_in,
    input wire logic [7:0] dio_in,
    output logic nrfd_oe_out,
    output logic ndac_oe_out,
    output logic [7:0] data_out,
    output logic eoi_out,
    output logic atn_out,
    output logic strobe_out
);
    import gpb_pkg::*;
    typedef struct packed {
        gpb_acc_t st;
        logic nrfd;
        logic ndac;
        logic [7:0] data;
        logic eoi;
        logic atn;
        logic strobe;
    } gpb_acc_st_t;
    gpb_acc_st_t q, n;
    always_comb begin
        n = q;
        n.strobe = 1'b0;
        case (q.st)
            ACC_IDLE: begin
                n.nrfd = 1'b0;
                n.ndac = 1'b0;
                if (enable_in) begin
                    n.ndac = 1'b1;
                    n.st = ACC_READY;
                end
            end
            ACC_READY: begin
                if (dav_in) begin
                    // Latch byte, then let source see acceptance
                    n.data = dio_in;
                    n.eoi = eoi_in;
                    n.atn = atn_in;
                    n.strobe = 1'b1;
                    n.nrfd = 1'b1;
                    n.ndac = 1'b0;
                    n.st = ACC_HOLD;
                end
            end
            ACC_HOLD: begin
                if (!dav_in) begin
                    n.nrfd = 1'b0;
                    n.ndac = 1'b1;
                    n.st = ACC_READY;
                end
            end
            default: n.st = ACC_IDLE;
        endcase
        if (!enable_in) begin
            n.nrfd = 1'b0;
            n.ndac = 1'b0;
            n.st = ACC_IDLE;
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
    assign nrfd_oe_out = q.nrfd;
    assign ndac_oe_out = q.ndac;
    assign data_out = q.data;
    assign eoi_out = q.eoi;
    assign atn_out = q.atn;
    assign strobe_out = q.strobe;
endmodule // gpb_acceptor
`default_nettype wire

// ### design/gpb_device.sv
// Overview of operation
// - Addressed commands need own listen address first
// - Controller starts addressing with unlisten
// - ATN held low through command bytes
// - Listen address is primary address plus group
// - Bytes with ATN high are data
// - Send data only when addressed to talk or in talk-only mode
// - Receive data only when addressed to listen
// - Own listen address ends talker state
// - Own talk address ends listener state
// - Talker: basic, talk-only, serial poll status
// - Source handshake for sent bytes
// - Acceptor handshake for received bytes
// - Service request to controller
// - Remote and local under bus control
// - Device clear pulses clear output, addressing and modes kept
// - Device trigger starts a reading
// - No parallel poll, configuration ignored
// - Never controller, never drives ATN
// - No secondary addressing
// - Listen address is address OR 0x20
// - Talk address is address OR 0x40
`timescale 1ns/1ns
`default_nettype none
module gpb_device (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    gpb_bus_if.dev bus,
    input wire logic [gpb_pkg::ADDR_W-1:0] addr_in,
    input wire logic talk_only_in,
    input wire logic local_in,
    input wire logic rsv_in,
    input wire logic [7:0] status_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_eoi_in,
    output logic tx_ack_out,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_eoi_out,
    output logic clear_out,
    output logic trigger_out,
    output logic listen_out,
    output logic talk_out,
    output logic remote_out,
    output logic lockout_out,
    output logic spoll_out
);
    import gpb_pkg::*;
    typedef struct packed {
        logic listen;
        logic talk;
        logic spoll;
        logic remote;
        logic lockout;
        logic polled;
        gpb_src_t src;
        logic [1:0] cnt;
        logic is_stb;
        logic [7:0] dio;
        logic dio_oe;
        logic dav_oe;
        logic eoi_oe;
        logic srq_oe;
        logic tx_ack;
        logic rx_valid;
        logic [7:0] rx_data;
        logic rx_eoi;
        logic clr;
        logic trig;
    } gpb_dev_st_t;
    gpb_dev_st_t q, n;
    logic acc_nrfd, acc_ndac, acc_eoi, acc_atn, acc_stb;
    logic [7:0] acc_data;
    logic [6:0] cmd;
    logic mine;
    logic can_send;
    // ****************************************
    // Acceptor
    // ****************************************
    // acceptor handshake
    gpb_acceptor u_acc (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(bus.atn | q.listen),
        .dav_in(bus.dav),
        .atn_in(bus.atn),
        .eoi_in(bus.eoi),
        .dio_in(bus.dio),
        .nrfd_oe_out(acc_nrfd),
        .ndac_oe_out(acc_ndac),
        .data_out(acc_data),
        .eoi_out(acc_eoi),
        .atn_out(acc_atn),
        .strobe_out(acc_stb)
    );
    assign cmd = acc_data[6:0];
    assign mine = (cmd[4:0] == addr_in);
    assign can_send = !bus.atn && (q.talk || talk_only_in);
    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = q;
        n.tx_ack = 1'b0;
        n.rx_valid = 1'b0;
        n.clr = 1'b0;
        n.trig = 1'b0;
        if (!bus.ren) begin
            n.remote = 1'b0;
            n.lockout = 1'b0;
        end else if (local_in && !q.lockout) begin
            n.remote = 1'b0;
        end
        if (acc_stb && acc_atn) begin
            case (cmd[6:5])
                GRP_LISTEN: begin
                    if (cmd == CMD_UNL) begin
                        n.listen = 1'b0;
                    end else if (mine) begin
                        n.listen = 1'b1;
                        n.talk = 1'b0;
                        n.remote = bus.ren;
                    end
                end
                GRP_TALK: begin
                    if (mine && cmd != CMD_UNT) begin
                        n.talk = 1'b1;
                        n.listen = 1'b0;
                    end else begin
                        n.talk = 1'b0;
                    end
                end
                GRP_CMD: begin
                    case (cmd)
                        CMD_DCL: begin
                            n.clr = 1'b1;
                            n.polled = 1'b0;
                        end
                        CMD_SDC: begin
                            if (q.listen) begin
                                n.clr = 1'b1;
                                n.polled = 1'b0;
                            end
                        end
                        CMD_GET: begin
                            n.trig = q.listen;
                        end
                        CMD_GTL: begin
                            if (q.listen) begin
                                n.remote = 1'b0;
                            end
                        end
                        CMD_LLO: n.lockout = 1'b1;
                        CMD_SPE: n.spoll = 1'b1;
                        CMD_SPD: n.spoll = 1'b0;
                        // parallel poll codes ignored, take control ignored
                        default: n.spoll = q.spoll;
                    endcase
                end
                default: n.listen = q.listen;
            endcase
        end else if (acc_stb && q.listen) begin
            n.rx_valid = 1'b1;
            n.rx_data = acc_data;
            n.rx_eoi = acc_eoi;
        end
        if (bus.ifc) begin
            n.listen = 1'b0;
            n.talk = 1'b0;
            n.spoll = 1'b0;
        end
        if (!rsv_in) begin
            n.polled = 1'b0;
        end
        case (q.src)
            SRC_IDLE: begin
                if (can_send && q.spoll && q.talk) begin
                    n.dio = status_in;
                    n.dio[STB_RQS_BIT] = q.srq_oe;
                    n.is_stb = 1'b1;
                    n.eoi_oe = 1'b0;
                    n.dio_oe = 1'b1;
                    n.cnt = SETTLE_CNT;
                    n.src = SRC_SETTLE;
                end else if (can_send && tx_valid_in) begin
                    n.dio = tx_data_in;
                    n.is_stb = 1'b0;
                    n.eoi_oe = tx_eoi_in;
                    n.dio_oe = 1'b1;
                    n.cnt = SETTLE_CNT;
                    n.src = SRC_SETTLE;
                end
            end
            SRC_SETTLE: begin
                if (q.cnt != 2'h0) begin
                    n.cnt = q.cnt - 2'h1;
                end else if (!bus.nrfd && bus.ndac) begin
                    n.dav_oe = 1'b1;
                    n.src = SRC_DAV;
                end
            end
            SRC_DAV: begin
                if (!bus.ndac) begin
                    n.dav_oe = 1'b0;
                    n.dio_oe = 1'b0;
                    n.eoi_oe = 1'b0;
                    n.src = SRC_IDLE;
                    if (q.is_stb) begin
                        n.polled = n.polled | q.srq_oe;
                    end else begin
                        n.tx_ack = 1'b1;
                    end
                end
            end
            default: n.src = SRC_IDLE;
        endcase
        if (!can_send) begin
            n.dio_oe = 1'b0;
            n.dav_oe = 1'b0;
            n.eoi_oe = 1'b0;
            n.src = SRC_IDLE;
        end
        n.srq_oe = rsv_in && !n.polled;
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
    // ****************************************
    // Outputs
    // ****************************************
    // no ATN, IFC or REN drive
    assign bus.dev_dio_out = q.dio;
    assign bus.dev_dio_oe = q.dio_oe;
    assign bus.dev_dav_oe = q.dav_oe;
    assign bus.dev_eoi_oe = q.eoi_oe;
    assign bus.dev_srq_oe = q.srq_oe;
    assign bus.dev_nrfd_oe = acc_nrfd;
    assign bus.dev_ndac_oe = acc_ndac;
    assign tx_ack_out = q.tx_ack;
    assign rx_valid_out = q.rx_valid;
    assign rx_data_out = q.rx_data;
    assign rx_eoi_out = q.rx_eoi;
    assign clear_out = q.clr;
    assign trigger_out = q.trig;
    assign listen_out = q.listen;
    assign talk_out = q.talk;
    assign remote_out = q.remote;
    assign lockout_out = q.lockout;
    assign spoll_out = q.spoll;
endmodule // gpb_device
`default_nettype wire

// ### design/gpb_controller.sv
`timescale 1ns/1ns
`default_nettype none
module gpb_controller (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    gpb_bus_if.ctl bus,
    input wire logic cmd_valid_in,
    input wire gpb_pkg::gpb_kind_t cmd_kind_in,
    input wire logic cmd_atn_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_eoi_in,
    output logic cmd_ack_out,
    input wire logic listen_en_in,
    output logic rd_valid_out,
    output logic [7:0] rd_data_out,
    output logic rd_eoi_out,
    input wire logic ren_in,
    input wire logic ifc_req_in,
    output logic srq_out
);
    import gpb_pkg::*;
    typedef struct packed {
        gpb_src_t src;
        logic [1:0] cnt;
        logic [10:0] ifc_cnt;
        logic [7:0] dio;
        logic dio_oe;
        logic dav_oe;
        logic eoi_oe;
        logic atn_oe;
        logic ifc_oe;
        logic ren_oe;
        logic ack;
        logic srq;
    } gpb_ctl_st_t;
    gpb_ctl_st_t q, n;
    logic acc_nrfd, acc_ndac, acc_stb, acc_eoi;
    logic [7:0] acc_data;
    gpb_acceptor u_acc (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(listen_en_in & !q.atn_oe),
        .dav_in(bus.dav),
        .atn_in(1'b0),
        .eoi_in(bus.eoi),
        .dio_in(bus.dio),
        .nrfd_oe_out(acc_nrfd),
        .ndac_oe_out(acc_ndac),
        .data_out(acc_data),
        .eoi_out(acc_eoi),
        .atn_out(),
        .strobe_out(acc_stb)
    );
    always_comb begin
        n = q;
        n.ack = 1'b0;
        n.ren_oe = ren_in;
        n.srq = bus.srq;
        if (q.ifc_cnt != 11'h000) begin
            n.ifc_cnt = q.ifc_cnt - 11'h001;
        end else if (ifc_req_in) begin
            n.ifc_cnt = IFC_CNT;
        end
        n.ifc_oe = (n.ifc_cnt != 11'h000);
        case (q.src)
            SRC_IDLE: begin
                if (cmd_valid_in && !q.ifc_oe) begin
                    // user opens with unlisten, ATN kept per byte
                    n.atn_oe = cmd_atn_in || cmd_kind_in != KIND_RAW;
                    n.dio = cmd_data_in;
                    if (cmd_kind_in == KIND_LISTEN) begin
                        n.dio = {1'b0, GRP_LISTEN, cmd_data_in[4:0]};
                    end else if (cmd_kind_in == KIND_TALK) begin
                        n.dio = {1'b0, GRP_TALK, cmd_data_in[4:0]};
                    end
                    n.eoi_oe = cmd_eoi_in && !n.atn_oe;
                    n.dio_oe = 1'b1;
                    n.cnt = SETTLE_CNT;
                    n.src = SRC_SETTLE;
                end else if (listen_en_in) begin
                    // release ATN so device talks data
                    n.atn_oe = 1'b0;
                end
            end
            SRC_SETTLE: begin
                if (q.cnt != 2'h0) begin
                    n.cnt = q.cnt - 2'h1;
                end else if (!bus.nrfd && bus.ndac) begin
                    n.dav_oe = 1'b1;
                    n.src = SRC_DAV;
                end
            end
            SRC_DAV: begin
                if (!bus.ndac) begin
                    n.dav_oe = 1'b0;
                    n.dio_oe = 1'b0;
                    n.eoi_oe = 1'b0;
                    n.ack = 1'b1;
                    n.src = SRC_IDLE;
                end
            end
            default: n.src = SRC_IDLE;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
    assign bus.ctl_dio_out = q.dio;
    assign bus.ctl_dio_oe = q.dio_oe;
    assign bus.ctl_dav_oe = q.dav_oe;
    assign bus.ctl_eoi_oe = q.eoi_oe;
    assign bus.ctl_atn_oe = q.atn_oe;
    assign bus.ctl_ifc_oe = q.ifc_oe;
    assign bus.ctl_ren_oe = q.ren_oe;
    assign bus.ctl_nrfd_oe = acc_nrfd;
    assign bus.ctl_ndac_oe = acc_ndac;
    assign cmd_ack_out = q.ack;
    assign rd_valid_out = acc_stb;
    assign rd_data_out = acc_data;
    assign rd_eoi_out = acc_eoi;
    assign srq_out = q.srq;
endmodule // gpb_controller
`default_nettype wire

// ### sim/gpb_sva.sv
`timescale 1ns/1ns
`default_nettype none
module gpb_sva #(
    parameter logic [4:0] ADDR = 5'h10
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] dio,
    input wire logic dav,
    input wire logic ndac,
    input wire logic atn,
    input wire logic ifc,
    input wire logic ctl_dav_oe,
    input wire logic [7:0] dev_dio_out,
    input wire logic dev_dio_oe,
    input wire logic dev_dav_oe,
    input wire logic dev_nrfd_oe,
    input wire logic dev_ndac_oe
);
    logic lsn;
    logic tlk;
    logic dav_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ****************************************
    // Address tracker
    // ****************************************
    always_ff @(posedge clk_in) begin
        dav_q <= dav;
        if (sys_rst_in || ifc) begin
            lsn <= 1'b0;
            tlk <= 1'b0;
        end else if (dav && !dav_q && atn) begin
            if (dio[6:0] == 7'h3F) begin
                lsn <= 1'b0;
            end else if (dio[6:5] == 2'h1 && dio[4:0] == ADDR) begin
                lsn <= 1'b1;
                tlk <= 1'b0;
            end else if (dio[6:5] == 2'h2) begin
                tlk <= (dio[4:0] == ADDR);
                if (dio[4:0] == ADDR) begin
                    lsn <= 1'b0;
                end
            end
        end
    end
    // ****************************************
    // Handshake checks
    // ****************************************
    sequence s_ctl_byte;
        $rose(ctl_dav_oe) && dev_ndac_oe;
    endsequence
    sequence s_src_start;
        $rose(dev_dav_oe);
    endsequence
    a_src_settle_time: assert property (s_src_start |-> dev_dio_oe && $past(dev_dio_oe, 3))
        else $error("device raised valid before data settled");
    a_src_data_stable: assert property (dev_dav_oe && $past(dev_dav_oe)
        |-> $stable(dev_dio_out) && dev_dio_oe)
        else $error("device data moved while valid");
    a_src_release_ack: assert property (dev_dav_oe && !ndac |=> !dev_dav_oe && !dev_dio_oe)
        else $error("device kept byte after acceptance");
    a_atn_stops_talk: assert property (atn [*2] |-> !dev_dio_oe && !dev_dav_oe)
        else $error("device drove data under attention");
    a_acc_latch_byte: assert property (s_ctl_byte |=> dev_nrfd_oe && !dev_ndac_oe)
        else $error("device did not accept byte in one cycle");
    a_acc_rearm_ready: assert property ($fell(dav) && dev_nrfd_oe |=> !dev_nrfd_oe)
        else $error("device stayed not ready after valid fell");
    a_unaddr_ignore_data: assert property ($rose(dav) && !atn && !lsn
        |-> !dev_ndac_oe && !dev_nrfd_oe)
        else $error("unaddressed device took part in data");
    a_talk_needs_addr: assert property ($rose(dev_dio_oe) |-> tlk)
        else $error("device sent without talk address");
endmodule // gpb_sva
`default_nettype wire

// ### sim/gpib_device_interface_tb.sv
`timescale 1ns/1ns
`default_nettype none
module gpib_device_interface_tb;
    import gpb_pkg::*;
    localparam logic [4:0] ADDR = 5'h10;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, rsv_in = 1'b0, tx_valid_in = 1'b0, tx_eoi_in = 1'b0;
    logic cmd_valid_in = 1'b0, cmd_atn_in = 1'b0, listen_en_in = 1'b0, ren_in = 1'b1;
    logic cmd_eoi_in = 1'b0;
    logic [7:0] status_in = 8'h01, tx_data_in = 8'h00, cmd_data_in = 8'h00;
    gpb_kind_t cmd_kind_in = KIND_RAW;
    logic tx_ack_out, rx_valid_out, rx_eoi_out, clear_out, trigger_out, listen_out, talk_out;
    logic remote_out, lockout_out, spoll_out, cmd_ack_out, rd_valid_out, rd_eoi_out, srq_out;
    logic [7:0] rx_data_out, rd_data_out;
    logic [7:0] rx_q[$], rd_q[$];
    int n_clr = 0, n_trg = 0, bad_count = 0, n_compared = 0;
    always #25 clk_in = ~clk_in;
    gpb_bus_if gpb_bus_if_i();
    gpb_device gpb_device_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(gpb_bus_if_i),
        .addr_in(ADDR), .talk_only_in(1'b0), .local_in(1'b0), .rsv_in(rsv_in),
        .status_in(status_in), .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
        .tx_eoi_in(tx_eoi_in), .tx_ack_out(tx_ack_out), .rx_valid_out(rx_valid_out),
        .rx_data_out(rx_data_out), .rx_eoi_out(rx_eoi_out), .clear_out(clear_out),
        .trigger_out(trigger_out), .listen_out(listen_out), .talk_out(talk_out),
        .remote_out(remote_out), .lockout_out(lockout_out), .spoll_out(spoll_out));
    gpb_controller gpb_controller_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .bus(gpb_bus_if_i), .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in),
        .cmd_atn_in(cmd_atn_in), .cmd_data_in(cmd_data_in), .cmd_eoi_in(cmd_eoi_in),
        .cmd_ack_out(cmd_ack_out), .listen_en_in(listen_en_in), .rd_valid_out(rd_valid_out),
        .rd_data_out(rd_data_out), .rd_eoi_out(rd_eoi_out), .ren_in(ren_in),
        .ifc_req_in(1'b0), .srq_out(srq_out));
    gpb_sva #(.ADDR(ADDR)) gpb_sva_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .dio(gpb_bus_if_i.dio), .dav(gpb_bus_if_i.dav), .ndac(gpb_bus_if_i.ndac),
        .atn(gpb_bus_if_i.atn), .ifc(gpb_bus_if_i.ifc), .ctl_dav_oe(gpb_bus_if_i.ctl_dav_oe),
        .dev_dio_out(gpb_bus_if_i.dev_dio_out), .dev_dio_oe(gpb_bus_if_i.dev_dio_oe),
        .dev_dav_oe(gpb_bus_if_i.dev_dav_oe), .dev_nrfd_oe(gpb_bus_if_i.dev_nrfd_oe),
        .dev_ndac_oe(gpb_bus_if_i.dev_ndac_oe));
    // ****************************************
    // Monitors and helpers
    // ****************************************
    always @(posedge clk_in) begin
        if (rx_valid_out === 1'b1)
            rx_q.push_back(rx_data_out);
        if (rd_valid_out === 1'b1)
            rd_q.push_back(rd_data_out);
        if (clear_out === 1'b1)
            n_clr++;
        if (trigger_out === 1'b1)
            n_trg++;
    end
    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (e !== g) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk1(input string name, input logic e, input logic g);
        n_compared++;
        if (e !== g) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic stop_test;
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_ack(input logic dev);
        int i;
        for (i = 0; i < 200 && (dev ? tx_ack_out : cmd_ack_out) !== 1'b1; i++)
            @(negedge clk_in);
        if (i == 200) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic send(input gpb_kind_t k, input logic a, input logic [7:0] d);
        @(negedge clk_in);
        cmd_kind_in = k;
        cmd_atn_in = a;
        cmd_data_in = d;
        cmd_valid_in = 1'b1;
        wait_ack(1'b0);
        cmd_valid_in = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic dev_send(input logic [7:0] d, input logic e);
        @(negedge clk_in);
        tx_data_in = d;
        tx_eoi_in = e;
        tx_valid_in = 1'b1;
        wait_ack(1'b1);
        tx_valid_in = 1'b0;
    endtask
    task automatic wait_rd(input int n);
        int i;
        for (i = 0; i < 200 && rd_q.size() < n; i++)
            @(negedge clk_in);
        chk8("bytes read", 8'(n), 8'(rd_q.size()));
        if (rd_q.size() < n)
            stop_test();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_addressing;
        send(KIND_RAW, 1'b1, 8'h04);
        chk8("clear before address", 8'h00, 8'(n_clr));
        send(KIND_RAW, 1'b1, 8'h3F);
        send(KIND_LISTEN, 1'b1, 8'(ADDR));
        chk1("listen", 1'b1, listen_out);
        chk1("remote", 1'b1, remote_out);
        send(KIND_RAW, 1'b1, 8'h04);
        chk8("selective clear", 8'h01, 8'(n_clr));
        send(KIND_RAW, 1'b1, 8'h14);
        chk8("universal clear", 8'h02, 8'(n_clr));
        send(KIND_TALK, 1'b1, 8'(ADDR));
        chk1("listen after talk", 1'b0, listen_out);
        chk1("talk", 1'b1, talk_out);
        send(KIND_LISTEN, 1'b1, 8'(ADDR));
        chk1("talk after listen", 1'b0, talk_out);
    endtask
    task automatic sc_data;
        logic [7:0] msg[4];
        msg = '{8'h2A, 8'h52, 8'h53, 8'h54};
        foreach (msg[i]) begin
            cmd_eoi_in = (i == 3);
            send(KIND_RAW, 1'b0, msg[i]);
        end
        cmd_eoi_in = 1'b0;
        chk1("data end", 1'b1, rx_eoi_out);
        chk8("data count", 8'h04, 8'(rx_q.size()));
        foreach (msg[i])
            chk8("data byte", msg[i], rx_q.pop_front());
    endtask
    task automatic sc_modes;
        send(KIND_RAW, 1'b1, 8'h08);
        chk8("trigger", 8'h01, 8'(n_trg));
        send(KIND_RAW, 1'b1, 8'h11);
        chk1("lockout", 1'b1, lockout_out);
        send(KIND_RAW, 1'b1, 8'h01);
        chk1("local", 1'b0, remote_out);
        send(KIND_RAW, 1'b1, 8'h05);
        send(KIND_RAW, 1'b1, 8'h65);
        chk1("listen kept", 1'b1, listen_out);
        chk8("clear kept", 8'h02, 8'(n_clr));
        send(KIND_RAW, 1'b1, 8'h3F);
        send(KIND_RAW, 1'b1, 8'h08);
        chk8("trigger unaddressed", 8'h01, 8'(n_trg));
        @(negedge clk_in);
        ren_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk1("lockout off", 1'b0, lockout_out);
    endtask
    task automatic sc_talk;
        tx_data_in = 8'hA5;
        tx_valid_in = 1'b1;
        listen_en_in = 1'b1;
        repeat (20) @(negedge clk_in);
        chk8("idle talker", 8'h00, 8'(rd_q.size()));
        listen_en_in = 1'b0;
        send(KIND_TALK, 1'b1, 8'(ADDR));
        listen_en_in = 1'b1;
        dev_send(8'hA5, 1'b0);
        dev_send(8'h3C, 1'b1);
        wait_rd(2);
        chk8("talk byte", 8'hA5, rd_q.pop_front());
        chk8("talk byte", 8'h3C, rd_q.pop_front());
        chk1("talk end", 1'b1, rd_eoi_out);
        listen_en_in = 1'b0;
        send(KIND_RAW, 1'b1, 8'h5F);
        chk1("untalk", 1'b0, talk_out);
    endtask
    task automatic sc_poll;
        rsv_in = 1'b1;
        repeat (4) @(negedge clk_in);
        chk1("service request", 1'b1, srq_out);
        send(KIND_RAW, 1'b1, 8'h18);
        send(KIND_TALK, 1'b1, 8'(ADDR));
        chk1("poll mode", 1'b1, spoll_out);
        listen_en_in = 1'b1;
        wait_rd(1);
        chk8("status byte", 8'h41, rd_q.pop_front());
        repeat (4) @(negedge clk_in);
        chk1("request served", 1'b0, srq_out);
        listen_en_in = 1'b0;
        send(KIND_RAW, 1'b1, 8'h19);
        send(KIND_RAW, 1'b1, 8'h5F);
        rd_q.delete();
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        sc_addressing();
        sc_data();
        sc_modes();
        sc_talk();
        sc_poll();
        stop_test();
    end
endmodule // gpib_device_interface_tb
`default_nettype wire
